// File: verilog/oivs_pkg.sv
// Package for the OTG ID and VBUS status block: register map, fields, resets.
// Assumes a 32-bit Avalon-MM slave with word addresses in bytes.
package oivs_pkg;
    // Register byte offsets
    localparam logic [7:0] OIVS_OTG_CTRL_OFS   = 8'h00;
    localparam logic [7:0] OIVS_USB_STAT_OFS   = 8'h04;
    localparam logic [7:0] OIVS_USB_RISE_OFS   = 8'h08;
    localparam logic [7:0] OIVS_USB_FALL_OFS   = 8'h0c;
    localparam logic [7:0] OIVS_CK_STAT_OFS    = 8'h10;
    localparam logic [7:0] OIVS_CK_RISE_OFS    = 8'h14;
    localparam logic [7:0] OIVS_CK_FALL_OFS    = 8'h18;
    localparam logic [7:0] OIVS_IF_CTRL_OFS    = 8'h1c;
    localparam logic [7:0] OIVS_RID_OFS        = 8'h20;
    localparam logic [7:0] OIVS_EVENT_OFS      = 8'h24;

    // OTG control fields
    localparam int OIVS_PULLUP_BIT    = 0;
    localparam int OIVS_DISCHARGE_BIT = 3;
    localparam int OIVS_CHARGE_BIT    = 4;
    // USB status / enable fields
    localparam int OIVS_VBUS_VALID_FLAG_BIT   = 1;
    localparam int OIVS_SESSION_VALID_FLAG_BIT   = 2;
    localparam int OIVS_SESSION_END_FLAG_BIT   = 3;
    localparam int OIVS_ID_GROUNDED_FLAG_BIT     = 4;
    // Carkit status / enable fields
    localparam int OIVS_ID_FLOATING_FLAG_BIT   = 0;
    // Interface control fields
    localparam int OIVS_EXTSEL_BIT    = 0;
    localparam int OIVS_BYPASS_BIT    = 1;
    localparam int OIVS_INVERT_BIT    = 2;

    // Reset values
    localparam logic [7:0] OIVS_OTG_CTRL_RST = 8'h00;
    localparam logic [7:0] OIVS_EN_RST       = 8'h1f;
    localparam logic [7:0] OIVS_CK_EN_RST    = 8'h00;
    localparam logic [7:0] OIVS_IF_CTRL_RST  = 8'h00;

    // ID resistance codes
    localparam logic [2:0] OIVS_RID_GND   = 3'h0;
    localparam logic [2:0] OIVS_RID_75    = 3'h1;
    localparam logic [2:0] OIVS_RID_102K  = 3'h2;
    localparam logic [2:0] OIVS_RID_200K  = 3'h3;
    localparam logic [2:0] OIVS_RID_FLOAT = 3'h5;

    localparam logic [31:0] OIVS_UNMAPPED = 32'h0000_0000;

    // Raw analog comparator levels
    typedef struct packed {
        logic id_gnd;
        logic id_float;
        logic sess_end;
        logic sess_vld;
        logic vbus_vld;
    } oivs_comp_t;

    // Receive-command event toward the link
    typedef struct packed {
        logic       valid;
        logic       alt_int;
        logic       irq;
        logic [1:0] vbus_state;
    } oivs_rxcmd_t;

    // Bus read answer
    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } oivs_rsp_t;
endpackage : oivs_pkg

// File: verilog/oivs_status.sv
// OTG ID pin and VBUS comparator status with receive-command events.
// Assumes comparators are asynchronous levels; bus and link share clk_i.
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
module oivs_status
    import oivs_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        clk_en_i,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Analog front end
    input  wire oivs_comp_t  comp_i,
    input  wire logic [2:0]  rid_code_i,
    output logic             id_sense_pullup_en_o,
    output logic             vbus_discharge_en_o,
    output logic             vbus_charge_en_o,
    output logic [4:0]       comp_enable_o,
    // Receive command toward the link
    output oivs_rxcmd_t      rxcmd_o
);
    // One stage cannot resolve a metastable comparator edge
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    // Control registers
    logic [7:0] otg_ctrl, usb_rise, usb_fall, ck_rise, ck_fall, if_ctrl;
    logic [7:0] next_otg_ctrl, next_usb_rise, next_usb_fall;
    logic [7:0] next_ck_rise, next_ck_fall, next_if_ctrl;
    logic [7:0] event_cnt, next_event_cnt;

    // Bus handshake: one wait cycle, answer on second
    logic        ack;
    logic        wreq_q, next_wreq;
    logic [31:0] rdata, next_rdata;

    // Synchronisers and last sampled levels
    logic [SYNC_STAGES-1:0] sync_q [5];
    logic [4:0] comp_s, comp_last, next_comp_last;
    logic [2:0] rid_q, next_rid_q;
    oivs_rxcmd_t rxcmd, next_rxcmd;

    // Comparator enables: [0]id_floating_flag [1]vbus [2]sess [3]session_end_flag [4]id_grounded_flag
    logic en_session_end_flag, en_vbus, en_id_floating_flag;
    logic [4:0] raw;
    logic ext_vbus;
    logic [4:0] flags;
    logic [4:0] rising, falling;
    logic vbus_report;
    logic wr_hit, rd_hit;

    assign raw = {comp_i.id_gnd, comp_i.sess_end, comp_i.sess_vld,
                  comp_i.vbus_vld, comp_i.id_float};
    assign ext_vbus = 1'b1;
    assign ack      = ~wreq_q;

    // Comparator synchronisers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < 5; i++) sync_q[i] <= '0;
        end else if (clk_en_i) begin
            for (int i = 0; i < 5; i++) begin
                sync_q[i] <= {sync_q[i][SYNC_STAGES-2:0], raw[i]};
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 5; i++) comp_s[i] = sync_q[i][SYNC_STAGES-1];
    end

    always_comb begin
        en_session_end_flag = usb_rise[OIVS_SESSION_END_FLAG_BIT] | usb_fall[OIVS_SESSION_END_FLAG_BIT];
        en_vbus    = usb_rise[OIVS_VBUS_VALID_FLAG_BIT] | usb_fall[OIVS_VBUS_VALID_FLAG_BIT];
        en_id_floating_flag = ck_rise[OIVS_ID_FLOATING_FLAG_BIT] | ck_fall[OIVS_ID_FLOATING_FLAG_BIT];
        // Disabled comparators read 0 and cannot toggle spuriously
        flags[0] = comp_s[0] & en_id_floating_flag;
        flags[1] = comp_s[1] & en_vbus;
        flags[2] = comp_s[2];
        flags[3] = comp_s[3] & en_session_end_flag;
        // Weak pull-up keeps ID sensing alive without the strong pull-up
        flags[4] = comp_s[4];
        rising   = flags & ~comp_last;
        falling  = ~flags & comp_last;
        // External indicator selection
        if (!if_ctrl[OIVS_EXTSEL_BIT]) begin
            vbus_report = flags[1];
        end else if (if_ctrl[OIVS_INVERT_BIT]) begin
            vbus_report = 1'b0;
        end else if (if_ctrl[OIVS_BYPASS_BIT]) begin
            vbus_report = ext_vbus;
        end else begin
            vbus_report = flags[1];
        end
    end

    // Event generation
    always_comb begin
        logic [4:0] irq_rise;
        logic [4:0] irq_fall;
        logic       chg;
        irq_rise = {usb_rise[OIVS_ID_GROUNDED_FLAG_BIT], usb_rise[OIVS_SESSION_END_FLAG_BIT],
                    usb_rise[OIVS_SESSION_VALID_FLAG_BIT], usb_rise[OIVS_VBUS_VALID_FLAG_BIT],
                    ck_rise[OIVS_ID_FLOATING_FLAG_BIT]};
        irq_fall = {usb_fall[OIVS_ID_GROUNDED_FLAG_BIT], usb_fall[OIVS_SESSION_END_FLAG_BIT],
                    usb_fall[OIVS_SESSION_VALID_FLAG_BIT], usb_fall[OIVS_VBUS_VALID_FLAG_BIT],
                    ck_fall[OIVS_ID_FLOATING_FLAG_BIT]};
        chg = |(rising | falling);
        next_comp_last = flags;
        next_rid_q     = rid_code_i;
        next_rxcmd.valid   = chg | (|(rising[2] | falling[2]));
        next_rxcmd.irq     = |((rising & irq_rise) | (falling & irq_fall));
        next_rxcmd.alt_int = rising[0] | falling[0];
        next_rxcmd.vbus_state = {vbus_report, flags[2]};
        next_event_cnt = chg ? event_cnt + 8'h01 : event_cnt;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            comp_last <= '0;
            rid_q     <= '0;
            rxcmd     <= '0;
            event_cnt <= '0;
        end else if (clk_en_i) begin
            comp_last <= next_comp_last;
            rid_q     <= next_rid_q;
            rxcmd     <= next_rxcmd;
            event_cnt <= next_event_cnt;
        end
    end

    // Register access
    function automatic logic [7:0] merge(input logic [7:0] old);
        merge = avs_byteenable_i[0] ? avs_writedata_i[7:0] : old;
    endfunction : merge

    always_comb begin
        // Writes land on the answer edge, reads are fetched one edge earlier
        wr_hit = avs_write_i & ack;
        rd_hit = avs_read_i & ~ack;
        next_wreq = ~((avs_read_i | avs_write_i) & wreq_q);
        next_otg_ctrl = otg_ctrl;
        next_usb_rise = usb_rise;
        next_usb_fall = usb_fall;
        next_ck_rise  = ck_rise;
        next_ck_fall  = ck_fall;
        next_if_ctrl  = if_ctrl;
        next_rdata    = rdata;
        if (wr_hit) begin
            unique case (avs_address_i)
                OIVS_OTG_CTRL_OFS: next_otg_ctrl = merge(otg_ctrl);
                OIVS_USB_RISE_OFS: next_usb_rise = merge(usb_rise);
                OIVS_USB_FALL_OFS: next_usb_fall = merge(usb_fall);
                OIVS_CK_RISE_OFS:  next_ck_rise  = merge(ck_rise);
                OIVS_CK_FALL_OFS:  next_ck_fall  = merge(ck_fall);
                OIVS_IF_CTRL_OFS:  next_if_ctrl  = merge(if_ctrl);
                default: ;
            endcase
        end
        if (rd_hit) begin
            unique case (avs_address_i)
                OIVS_OTG_CTRL_OFS: next_rdata = {24'h0, otg_ctrl};
                OIVS_USB_STAT_OFS: next_rdata = {27'h0, flags[4], flags[3],
                                                  flags[2], flags[1], 1'b0};
                OIVS_USB_RISE_OFS: next_rdata = {24'h0, usb_rise};
                OIVS_USB_FALL_OFS: next_rdata = {24'h0, usb_fall};
                OIVS_CK_STAT_OFS:  next_rdata = {31'h0, flags[0]};
                OIVS_CK_RISE_OFS:  next_rdata = {24'h0, ck_rise};
                OIVS_CK_FALL_OFS:  next_rdata = {24'h0, ck_fall};
                OIVS_IF_CTRL_OFS:  next_rdata = {24'h0, if_ctrl};
                OIVS_RID_OFS:      next_rdata = {29'h0, rid_q};
                OIVS_EVENT_OFS:    next_rdata = {24'h0, event_cnt};
                default:           next_rdata = OIVS_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            otg_ctrl <= OIVS_OTG_CTRL_RST;
            usb_rise <= OIVS_EN_RST;
            usb_fall <= OIVS_EN_RST;
            ck_rise  <= OIVS_CK_EN_RST;
            ck_fall  <= OIVS_CK_EN_RST;
            if_ctrl  <= OIVS_IF_CTRL_RST;
            wreq_q   <= 1'b1;
            rdata    <= '0;
        end else if (clk_en_i) begin
            otg_ctrl <= next_otg_ctrl;
            usb_rise <= next_usb_rise;
            usb_fall <= next_usb_fall;
            ck_rise  <= next_ck_rise;
            ck_fall  <= next_ck_fall;
            if_ctrl  <= next_if_ctrl;
            wreq_q   <= next_wreq;
            rdata    <= next_rdata;
        end
    end

    // Outputs registered
    logic pull_q, dis_q, chg_q;
    logic [4:0] cen_q;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pull_q <= 1'b0;
            dis_q  <= 1'b0;
            chg_q  <= 1'b0;
            cen_q  <= '0;
        end else if (clk_en_i) begin
            pull_q <= next_otg_ctrl[OIVS_PULLUP_BIT];
            dis_q  <= next_otg_ctrl[OIVS_DISCHARGE_BIT];
            chg_q  <= next_otg_ctrl[OIVS_CHARGE_BIT];
            cen_q  <= {1'b1,
                       next_usb_rise[OIVS_SESSION_END_FLAG_BIT] | next_usb_fall[OIVS_SESSION_END_FLAG_BIT],
                       1'b1,
                       next_usb_rise[OIVS_VBUS_VALID_FLAG_BIT] | next_usb_fall[OIVS_VBUS_VALID_FLAG_BIT],
                       next_ck_rise[OIVS_ID_FLOATING_FLAG_BIT] | next_ck_fall[OIVS_ID_FLOATING_FLAG_BIT]};
        end
    end

    assign avs_readdata_o       = rdata;
    assign avs_waitrequest_o    = wreq_q;
    assign id_sense_pullup_en_o = pull_q;
    assign vbus_discharge_en_o  = dis_q;
    assign vbus_charge_en_o     = chg_q;
    assign comp_enable_o        = cen_q;
    assign rxcmd_o              = rxcmd;

    // Checks
    default clocking cb_chk @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // Disabled comparators must read zero
    a_vbus_disabled_zero: assert property (
        !en_vbus |-> !flags[1]) else $error("vbus flag set while disabled");

    a_session_end_flag_disabled: assert property (
        !en_session_end_flag |-> !flags[3]) else $error("session_end_flag flag set while disabled");

    a_id_floating_flag_gate: assert property (
        !en_id_floating_flag |-> !flags[0]) else $error("id float flag set while disabled");

    // Enabled or free-running comparators follow their synchronised level
    a_session_end_flag_follows: assert property (
        en_session_end_flag |-> flags[3] == comp_s[3]) else $error("session_end_flag flag lost level");

    a_id_grounded_flag_follows: assert property (
        flags[4] == comp_s[4]) else $error("id ground flag lost level");

    a_session_valid_flag_free: assert property (
        flags[2] == comp_s[2]) else $error("session valid flag gated");

    // Every change reaches the link once
    a_session_valid_flag_event: assert property (
        clk_en_i && (flags[2] != comp_last[2]) |=> rxcmd.valid)
        else $error("session valid change without event");

    a_id_floating_flag_alt: assert property (
        clk_en_i && en_id_floating_flag && (flags[0] != comp_last[0]) |=> rxcmd.alt_int)
        else $error("id float event without alt bit");

    a_alt_only_float: assert property (
        clk_en_i && !(rising[0] || falling[0]) |=> !rxcmd.alt_int)
        else $error("alt bit without id float change");

    a_one_event: assert property (
        clk_en_i && rxcmd.valid && $stable(comp_s) |=> !rxcmd.valid)
        else $error("repeated event for one change");

    a_no_change_quiet: assert property (
        clk_en_i && ((rising | falling) == 5'h00) |=> !rxcmd.valid)
        else $error("event without a change");

    // Interrupt qualifier only rides on an event
    a_id_grounded_flag_irq_gate: assert property (
        clk_en_i && rising[4] && !usb_rise[OIVS_ID_GROUNDED_FLAG_BIT] && rising[3:0] == 4'h0
        && falling == 5'h0 |=> !rxcmd.irq) else $error("id ground irq not gated");

    a_irq_needs_event: assert property (
        rxcmd.irq |-> rxcmd.valid) else $error("irq without event");

    // Indicator selection
    a_invert_zero: assert property (
        if_ctrl[OIVS_EXTSEL_BIT] && if_ctrl[OIVS_INVERT_BIT] |-> !vbus_report)
        else $error("invert did not force zero");

    a_bypass_one: assert property (
        if_ctrl[OIVS_EXTSEL_BIT] && if_ctrl[OIVS_BYPASS_BIT] && !if_ctrl[OIVS_INVERT_BIT]
        |-> vbus_report) else $error("bypass did not give one");

    a_qualified_direct: assert property (
        if_ctrl[OIVS_EXTSEL_BIT] && !if_ctrl[OIVS_BYPASS_BIT] && !if_ctrl[OIVS_INVERT_BIT]
        |-> vbus_report == flags[1]) else $error("qualified source not comparator");

    a_reset_internal: assert property (
        !if_ctrl[OIVS_EXTSEL_BIT] |-> vbus_report == flags[1])
        else $error("internal source not used");

    // Pin controls and resistance code
    a_pulse_resistors: assert property (
        vbus_discharge_en_o == otg_ctrl[OIVS_DISCHARGE_BIT]
        && vbus_charge_en_o == otg_ctrl[OIVS_CHARGE_BIT])
        else $error("pulsing resistor control mismatch");

    a_rid_track: assert property (
        clk_en_i |=> rid_q == $past(rid_code_i)) else $error("resistance code stale");

    // Bus answers after one wait cycle and never holds it low twice
    a_bus_answer: assert property (
        clk_en_i && (avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !clk_en_i || !avs_waitrequest_o) else $error("bus answer late");

    a_wait_one: assert property (
        clk_en_i && !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("bus answer held too long");

    c_sess_event: cover property (rxcmd.valid);
    c_alt_event: cover property (rxcmd.alt_int);
    c_irq_event: cover property (rxcmd.irq);
    c_ext_event: cover property (rxcmd.valid && if_ctrl[OIVS_EXTSEL_BIT]);
    c_session_end_flag_event: cover property (rxcmd.valid && comp_last[3]);
endmodule : oivs_status

// File: sim/oivs_link_model.sv
// Link-side partner: collects receive commands sent by the status block.
// Assumes rxcmd_i is a one-cycle pulse on clk_i; no answer goes back.
module oivs_link_model
    import oivs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Receive command from the block
    input  wire oivs_rxcmd_t rxcmd_i,
    // Observations for the bench
    output int               evt_cnt_o,
    output oivs_rxcmd_t      last_o,
    output logic             started_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            evt_cnt_o <= 0;
            last_o    <= '0;
            started_o <= 1'b0;
        end else if (rxcmd_i.valid) begin
            evt_cnt_o <= evt_cnt_o + 1;
            last_o    <= rxcmd_i;
            // Peripheral start follows session valid, never vbus valid
            started_o <= rxcmd_i.vbus_state[0];
        end
    end
endmodule : oivs_link_model

// File: sim/oivs_status_tb.sv
// Self-checking bench for the OTG ID and VBUS status block.
// Assumes one 100 MHz clock; the link side is oivs_link_model.
module oivs_status_tb import oivs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // Settle wait scaled down from milliseconds to keep the run short
    localparam int ID_WAIT = 50;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic [7:0]  avs_address_i = 8'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    oivs_comp_t  comp_i = 5'h18;
    logic [2:0]  rid_code_i = 3'h5;
    logic        pullup_o;
    logic        dis_o;
    logic        chg_o;
    oivs_rxcmd_t rxcmd_o;
    int          evt_cnt;
    oivs_rxcmd_t last_evt;
    logic [4:0]  cen;
    logic        started;
    int          miscompares = 0;
    int          checked = 0;
    int          exp_reg [int];
    logic [31:0] rd;
    logic [31:0] v;
    oivs_comp_t  c;

    oivs_status #(.SYNC_STAGES(2)) oivs_status_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .clk_en_i(1'b1),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .comp_i(comp_i), .rid_code_i(rid_code_i),
        .id_sense_pullup_en_o(pullup_o), .vbus_discharge_en_o(dis_o),
        .vbus_charge_en_o(chg_o), .comp_enable_o(cen), .rxcmd_o(rxcmd_o));
    oivs_link_model oivs_link_model_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .rxcmd_i(rxcmd_o),
        .evt_cnt_o(evt_cnt), .last_o(last_evt), .started_o(started));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        avs_address_i    <= a;
        avs_writedata_i  <= d;
        avs_byteenable_i <= be;
        avs_write_i      <= w;
        avs_read_i       <= !w;
        @(posedge clk_i);
        // Only the watchdog ends a hung wait
        while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        // Idle edge so the next request is a fresh assignment
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        bus(1'b1, a, d, be);
        if (be[0]) exp_reg[a] = d;
    endtask : wr

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        check(name, rd, exp);
    endtask : rdchk

    function automatic logic [31:0] usb_stat();
        logic [7:0] en;
        en = 8'(exp_reg[8] | exp_reg[12]);
        return {27'h0, comp_i.id_gnd, comp_i.sess_end & en[3], comp_i.sess_vld,
                comp_i.vbus_vld & en[1], 1'b0};
    endfunction : usb_stat

    // Change the comparators, then compare events and both status words
    task automatic stim(input oivs_comp_t cv, input int d, input logic irq, input logic alt);
        int c0;
        repeat (6) @(posedge clk_i);
        c0 = evt_cnt;
        comp_i <= cv;
        repeat (6) @(posedge clk_i);
        check("events", 32'(evt_cnt), 32'(c0 + d));
        if (d > 0) begin
            check("irq", {31'h0, last_evt.irq}, {31'h0, irq});
            check("alt_int", {31'h0, last_evt.alt_int}, {31'h0, alt});
        end
        rdchk("usb status", OIVS_USB_STAT_OFS, usb_stat());
        rdchk("carkit status", OIVS_CK_STAT_OFS,
              {31'h0, comp_i.id_float & (exp_reg[20][0] | exp_reg[24][0])});
    endtask : stim

    initial begin
        #300000;
        miscompares++;
        test_done();
    end

    initial begin
        void'($urandom(58));
        exp_reg = '{0: 32'(OIVS_OTG_CTRL_RST), 8: 32'(OIVS_EN_RST), 12: 32'(OIVS_EN_RST),
                    20: 32'(OIVS_CK_EN_RST), 24: 32'(OIVS_CK_EN_RST), 28: 32'(OIVS_IF_CTRL_RST)};
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        foreach (exp_reg[a]) rdchk("reset value", 8'(a), exp_reg[a]);
        rdchk("unmapped", 8'hfc, OIVS_UNMAPPED);
        check("comp enable", {27'h0, cen}, 32'h1e);
        repeat (4) begin
            v = $urandom & 32'h19;
            wr(OIVS_OTG_CTRL_OFS, v, 4'h1);
            wr(OIVS_OTG_CTRL_OFS, ~v & 32'h19, 4'h0);
            check("pull outputs", {29'h0, chg_o, dis_o, pullup_o}, {29'h0, v[4], v[3], v[0]});
        end
        rdchk("otg ctrl", OIVS_OTG_CTRL_OFS, exp_reg[0]);
        wr(OIVS_OTG_CTRL_OFS, 32'h01, 4'h1);
        repeat (ID_WAIT) @(posedge clk_i);
        rdchk("usb status", OIVS_USB_STAT_OFS, usb_stat());
        wr(OIVS_CK_RISE_OFS, 32'h01, 4'h1);
        wr(OIVS_CK_FALL_OFS, 32'h01, 4'h1);
        stim(5'h10, 1, 1'b1, 1'b1);
        wr(OIVS_OTG_CTRL_OFS, 32'h00, 4'h1);
        stim(5'h00, 1, 1'b1, 1'b0);
        wr(OIVS_USB_RISE_OFS, 32'h0f, 4'h1);
        wr(OIVS_USB_FALL_OFS, 32'h0f, 4'h1);
        stim(5'h10, 1, 1'b0, 1'b0);
        wr(OIVS_USB_RISE_OFS, 32'h1b, 4'h1);
        wr(OIVS_USB_FALL_OFS, 32'h1b, 4'h1);
        stim(5'h12, 1, 1'b0, 1'b0);
        stim(5'h16, 1, 1'b1, 1'b0);
        wr(OIVS_USB_RISE_OFS, 32'h13, 4'h1);
        wr(OIVS_USB_FALL_OFS, 32'h13, 4'h1);
        stim(5'h12, 0, 1'b0, 1'b0);
        stim(5'h13, 1, 1'b1, 1'b0);
        wr(OIVS_USB_RISE_OFS, 32'h11, 4'h1);
        wr(OIVS_USB_FALL_OFS, 32'h11, 4'h1);
        stim(5'h13, 0, 1'b0, 1'b0);
        check("comp enable", {27'h0, cen}, 32'h15);
        wr(OIVS_USB_RISE_OFS, 32'h1f, 4'h1);
        wr(OIVS_USB_FALL_OFS, 32'h1f, 4'h1);
        for (int i = 0; i < 8; i++) begin
            wr(OIVS_IF_CTRL_OFS, 32'(i), 4'h1);
            c = comp_i;
            c.vbus_vld = 1'($urandom);
            c.sess_vld = !c.sess_vld;
            stim(c, 1, 1'b1, 1'b0);
            v = (i[0] == 1'b0) ? c.vbus_vld : (i[2] ? 0 : (i[1] ? 1 : c.vbus_vld));
            check("vbus_state", {30'h0, last_evt.vbus_state}, {30'h0, v[0], c.sess_vld});
            check("started", {31'h0, started}, {31'h0, c.sess_vld});
        end
        repeat (6) begin
            rid_code_i <= 3'($urandom_range(0, 4) == 4 ? 5 : $urandom_range(0, 3));
            repeat (4) @(posedge clk_i);
            rdchk("rid code", OIVS_RID_OFS, {29'h0, rid_code_i});
        end
        test_done();
    end
endmodule : oivs_status_tb
